/* File: verilog/irq_gen_pkg.sv */
// Constants for the dual interrupt generator
package irq_gen_pkg;
  localparam int NUM_GEN = 2;
  localparam int NUM_EVT = 6;
  localparam int NUM_LINES = 7;
  localparam int PRIO_W = 3;
  localparam logic [5:0] MASK_RST = 6'h00;
  localparam logic [2:0] PRIO_RST = 3'h0;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  localparam int BIT_FIFO_NONEMPTY = 0;
  localparam int BIT_BLOCK_COMPLETE = 1;
  localparam int BIT_ARMED_WAITING = 2;
  localparam int BIT_ACQ_STOPPED = 3;
  localparam int BIT_OVER_RANGE = 4;
  localparam int BIT_CONV_FAULT = 5;
endpackage : irq_gen_pkg

/* File: verilog/irq_line_decode.sv */
// One generator: event gating and line decode
module irq_line_decode (
  input wire logic [5:0] evt_in,
  input wire logic [5:0] mask_in,
  input wire logic [2:0] prio_in,
  output logic active_out,
  output logic [6:0] lines_out
);
  always_comb begin
    active_out = (|(evt_in & mask_in)) && (prio_in != irq_gen_pkg::PRIO_OFF);
    lines_out = 7'h00;
    if (active_out) begin
      lines_out[prio_in - 3'h1] = 1'b1;
    end
  end
endmodule : irq_line_decode

/* File: verilog/dual_vme_interrupt_generator.sv */
// Two independent interrupt generators driving seven request lines
module dual_vme_interrupt_generator (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic evt_fifo_nonempty_in,
  input wire logic evt_block_complete_in,
  input wire logic evt_armed_waiting_in,
  input wire logic evt_acquisition_stopped_in,
  input wire logic evt_input_over_range_in,
  input wire logic evt_converter_fault_in,
  input wire logic generator_index_in,
  input wire logic mask_wr_in,
  input wire logic [5:0] mask_wdata_in,
  input wire logic prio_wr_in,
  input wire logic [2:0] prio_wdata_in,
  output logic [5:0] mask_rdata_out,
  output logic [2:0] prio_rdata_out,
  output logic [1:0] gen_active_out,
  output logic [6:0] irq_lines_out
);
  logic [5:0] evt_s1_ff;
  logic [5:0] evt_ff;
  logic [5:0] mask_ff [2];
  logic [5:0] nxt_mask [2];
  logic [2:0] prio_ff [2];
  logic [2:0] nxt_prio [2];
  logic [5:0] evt_raw;
  logic [6:0] lines_g [2];
  logic [1:0] act;
  logic [6:0] nxt_lines;
  logic [6:0] lines_ff;
  logic [1:0] act_ff;
  logic [5:0] nxt_mrd;
  logic [2:0] nxt_prd;
  logic [2:0] hold_cnt_ff;
  logic [2:0] nxt_hold_cnt;

  function automatic logic sel_match(input logic idx, input int g);
    return idx == g[0];
  endfunction : sel_match

  function automatic logic [6:0] line_bit(input logic [2:0] prio);
    line_bit = 7'h00;
    if (prio != irq_gen_pkg::PRIO_OFF) begin
      line_bit[prio - 3'h1] = 1'b1;
    end
  endfunction : line_bit

  // Counts consecutive edges with an enabled raw event on generator 0 and no setting write, saturating at 7
  always_comb begin
    nxt_hold_cnt = 3'h0;
    if ((|(evt_raw & mask_ff[0])) && (prio_ff[0] != irq_gen_pkg::PRIO_OFF)
        && !mask_wr_in && !prio_wr_in) begin
      nxt_hold_cnt = hold_cnt_ff;
      if (hold_cnt_ff != 3'h7) begin
        nxt_hold_cnt = hold_cnt_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hold_cnt_ff <= 3'h0;
    end else begin
      hold_cnt_ff <= nxt_hold_cnt;
    end
  end

  always_comb begin
    evt_raw = 6'h00;
    evt_raw[irq_gen_pkg::BIT_FIFO_NONEMPTY] = evt_fifo_nonempty_in;
    evt_raw[irq_gen_pkg::BIT_BLOCK_COMPLETE] = evt_block_complete_in;
    evt_raw[irq_gen_pkg::BIT_ARMED_WAITING] = evt_armed_waiting_in;
    evt_raw[irq_gen_pkg::BIT_ACQ_STOPPED] = evt_acquisition_stopped_in;
    evt_raw[irq_gen_pkg::BIT_OVER_RANGE] = evt_input_over_range_in;
    evt_raw[irq_gen_pkg::BIT_CONV_FAULT] = evt_converter_fault_in;
  end

  // Events come from other logic domains: two-stage sync
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      evt_s1_ff <= 6'h00;
      evt_ff <= 6'h00;
    end else begin
      evt_s1_ff <= evt_raw;
      evt_ff <= evt_s1_ff;
    end
  end

  // Settings, index one bit wide so only 0 or 1 reachable
  always_comb begin
    for (int g = 0; g < irq_gen_pkg::NUM_GEN; g++) begin
      nxt_mask[g] = mask_ff[g];
      nxt_prio[g] = prio_ff[g];
      if (mask_wr_in && sel_match(generator_index_in, g)) begin
        nxt_mask[g] = mask_wdata_in;
      end
      if (prio_wr_in && sel_match(generator_index_in, g)) begin
        nxt_prio[g] = prio_wdata_in;
      end
    end
    nxt_mrd = mask_ff[generator_index_in];
    nxt_prd = prio_ff[generator_index_in];
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int g = 0; g < irq_gen_pkg::NUM_GEN; g++) begin
        mask_ff[g] <= irq_gen_pkg::MASK_RST;
        prio_ff[g] <= irq_gen_pkg::PRIO_RST;
      end
      mask_rdata_out <= irq_gen_pkg::MASK_RST;
      prio_rdata_out <= irq_gen_pkg::PRIO_RST;
    end else begin
      for (int g = 0; g < irq_gen_pkg::NUM_GEN; g++) begin
        mask_ff[g] <= nxt_mask[g];
        prio_ff[g] <= nxt_prio[g];
      end
      mask_rdata_out <= nxt_mrd;
      prio_rdata_out <= nxt_prd;
    end
  end

  irq_line_decode u_gen0 (
    .evt_in(evt_ff),
    .mask_in(mask_ff[0]),
    .prio_in(prio_ff[0]),
    .active_out(act[0]),
    .lines_out(lines_g[0])
  );

  irq_line_decode u_gen1 (
    .evt_in(evt_ff),
    .mask_in(mask_ff[1]),
    .prio_in(prio_ff[1]),
    .active_out(act[1]),
    .lines_out(lines_g[1])
  );

  always_comb begin
    nxt_lines = lines_g[0] | lines_g[1];
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lines_ff <= 7'h00;
      act_ff <= 2'h0;
    end else begin
      lines_ff <= nxt_lines;
      act_ff <= act;
    end
  end

  assign irq_lines_out = lines_ff;
  assign gen_active_out = act_ff;

  a_off_no_line: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (prio_ff[0] == irq_gen_pkg::PRIO_OFF) |=> !act_ff[0])
    else $error("generator 0 active with priority zero");

  a_off_no_line_b: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (prio_ff[1] == irq_gen_pkg::PRIO_OFF) |=> !act_ff[1])
    else $error("generator 1 active with priority zero");

  a_line_follows_prio: assert property (@(posedge clk_in) disable iff (!nrst_in)
    act[0] |=> irq_lines_out[$past(prio_ff[0]) - 3'h1])
    else $error("generator 0 line not the priority line");

  a_line_follows_b: assert property (@(posedge clk_in) disable iff (!nrst_in)
    act[1] |=> irq_lines_out[$past(prio_ff[1]) - 3'h1])
    else $error("generator 1 line not the priority line");

  a_seven_top_line: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (act[1] && prio_ff[1] == 3'h7) |=> irq_lines_out[6])
    else $error("priority seven did not drive top line");

  a_seven_top_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (act[0] && prio_ff[0] == 3'h7) |=> irq_lines_out[6])
    else $error("generator 0 priority seven missed top line");

  a_lines_are_or: assert property (@(posedge clk_in) disable iff (!nrst_in)
    1'b1 |=> irq_lines_out == $past(line_bit(act[0] ? prio_ff[0] : irq_gen_pkg::PRIO_OFF)
      | line_bit(act[1] ? prio_ff[1] : irq_gen_pkg::PRIO_OFF)))
    else $error("request lines are not the union of both generators");

  a_idle_no_line: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (gen_active_out == 2'h0) |-> (irq_lines_out == 7'h00))
    else $error("line driven with no active generator");

  a_any_event_fires: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ((|(evt_ff & mask_ff[0])) && prio_ff[0] != 3'h0) |=> gen_active_out[0])
    else $error("enabled event did not raise request");

  a_any_event_b: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ((|(evt_ff & mask_ff[1])) && prio_ff[1] != 3'h0) |=> gen_active_out[1])
    else $error("enabled event did not raise generator 1 request");

  a_event_path_sync: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (evt_fifo_nonempty_in && mask_ff[0][irq_gen_pkg::BIT_FIFO_NONEMPTY]
      && prio_ff[0] != irq_gen_pkg::PRIO_OFF)[*3] |=> irq_lines_out[$past(prio_ff[0]) - 3'h1])
    else $error("fifo event did not reach line");

  a_sync_block: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $past(nrst_in, 2) |-> evt_ff[irq_gen_pkg::BIT_BLOCK_COMPLETE] == $past(evt_block_complete_in, 2))
    else $error("block event not carried through sync");

  a_sync_armed: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $past(nrst_in, 2) |-> evt_ff[irq_gen_pkg::BIT_ARMED_WAITING] == $past(evt_armed_waiting_in, 2))
    else $error("armed event not carried through sync");

  a_sync_stopped: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $past(nrst_in, 2) |-> evt_ff[irq_gen_pkg::BIT_ACQ_STOPPED] == $past(evt_acquisition_stopped_in, 2))
    else $error("stopped event not carried through sync");

  a_sync_range: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $past(nrst_in, 2) |-> evt_ff[irq_gen_pkg::BIT_OVER_RANGE] == $past(evt_input_over_range_in, 2))
    else $error("over range event not carried through sync");

  a_sync_fault: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $past(nrst_in, 2) |-> evt_ff[irq_gen_pkg::BIT_CONV_FAULT] == $past(evt_converter_fault_in, 2))
    else $error("fault event not carried through sync");

  a_steady_request: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (hold_cnt_ff >= 3'h3) |-> gen_active_out[0])
    else $error("request missing while enabled event held");

  a_drop_when_clear: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!(|(evt_ff & mask_ff[1]))) |=> !gen_active_out[1])
    else $error("request held with no enabled event");

  a_drop_clear_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!(|(evt_ff & mask_ff[0]))) |=> !gen_active_out[0])
    else $error("generator 0 request held with no enabled event");

  a_zero_prio_quiet: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (prio_ff[0] == irq_gen_pkg::PRIO_OFF && prio_ff[1] == irq_gen_pkg::PRIO_OFF)
    |=> (irq_lines_out == 7'h00))
    else $error("line driven with both generators off");

  a_mask_write_sep: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (mask_wr_in && !prio_wr_in) |=> $stable(prio_ff[0]) && $stable(prio_ff[1]))
    else $error("mask write disturbed priority");

  a_prio_write_sep: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (prio_wr_in && !mask_wr_in) |=> $stable(mask_ff[0]) && $stable(mask_ff[1]))
    else $error("priority write disturbed mask");

  a_index_isolated: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (mask_wr_in && generator_index_in) |=> $stable(mask_ff[0]))
    else $error("write to generator 1 changed generator 0");

  a_index_isolated_b: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (mask_wr_in && !generator_index_in) |=> $stable(mask_ff[1]))
    else $error("write to generator 0 changed generator 1");

  a_prio_isolated: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (prio_wr_in && generator_index_in) |=> $stable(prio_ff[0]))
    else $error("priority write to generator 1 changed generator 0");

  a_readback: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (prio_wr_in && !generator_index_in) ##1 !generator_index_in
    |=> prio_rdata_out == $past(prio_wdata_in, 2))
    else $error("priority readback mismatch");

  a_mask_readback: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (mask_wr_in && generator_index_in) ##1 generator_index_in
    |=> mask_rdata_out == $past(mask_wdata_in, 2))
    else $error("mask readback mismatch");

  a_write_lands: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (mask_wr_in && !generator_index_in) |=> mask_ff[0] == $past(mask_wdata_in))
    else $error("mask write did not land");

  c_both_active: cover property (@(posedge clk_in) disable iff (!nrst_in) act_ff == 2'h3);
  c_mask_wr_b: cover property (@(posedge clk_in) disable iff (!nrst_in)
    mask_wr_in && generator_index_in);
  c_top_line: cover property (@(posedge clk_in) disable iff (!nrst_in) irq_lines_out[6]);
  c_fault_irq: cover property (@(posedge clk_in) disable iff (!nrst_in)
    evt_ff[irq_gen_pkg::BIT_CONV_FAULT] && act_ff[0]);
  c_release: cover property (@(posedge clk_in) disable iff (!nrst_in) $fell(act_ff[1]));
endmodule : dual_vme_interrupt_generator

/* File: tb/irq_handler_model.sv */
// Backplane handler model: reports the highest pending request line
module irq_handler_model (
  input wire logic [6:0] lines_in,
  output logic [2:0] level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  always_comb begin
    level_out = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (lines_in[i]) begin
        level_out = 3'(i + 1);
      end
    end
  end
endmodule : irq_handler_model

/* File: tb/testbench.sv */
// Self-checking bench for the dual interrupt generator
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic nrst_n = 1'b0;
  logic [5:0] evt = 6'h00;
  logic idx = 1'b0;
  logic mwr = 1'b0;
  logic pwr = 1'b0;
  logic [5:0] mdat = 6'h00;
  logic [2:0] pdat = 3'h0;
  logic [5:0] mrd;
  logic [2:0] prd;
  logic [1:0] act;
  logic [6:0] lines;
  logic [2:0] lvl;
  int err_count = 0;
  int total_checks = 0;
  dual_vme_interrupt_generator i_dut (.clk_in(clk), .nrst_in(nrst_n),
    .evt_fifo_nonempty_in(evt[0]), .evt_block_complete_in(evt[1]),
    .evt_armed_waiting_in(evt[2]), .evt_acquisition_stopped_in(evt[3]),
    .evt_input_over_range_in(evt[4]), .evt_converter_fault_in(evt[5]),
    .generator_index_in(idx), .mask_wr_in(mwr), .mask_wdata_in(mdat), .prio_wr_in(pwr),
    .prio_wdata_in(pdat), .mask_rdata_out(mrd), .prio_rdata_out(prd),
    .gen_active_out(act), .irq_lines_out(lines));
  irq_handler_model i_handler (.lines_in(lines), .level_out(lvl));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic i, input logic wm, input logic [5:0] m, input logic wp,
                    input logic [2:0] p);
    @(negedge clk);
    idx = i;
    mwr = wm;
    mdat = m;
    pwr = wp;
    pdat = p;
    @(negedge clk);
    mwr = 1'b0;
    pwr = 1'b0;
  endtask : wr
  task automatic rd(input logic i, input logic [5:0] m, input logic [2:0] p);
    @(negedge clk);
    idx = i;
    @(negedge clk);
    chk(7'(mrd), 7'(m));
    chk(7'(prd), 7'(p));
  endtask : rd
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  initial begin
    #200000;
    err_count++;
    test_done();
  end
  task automatic test_reset();
    chk(lines, 7'h00);
    chk(7'(act), 7'h00);
    rd(1'b0, 6'h00, 3'h0);
    rd(1'b1, 6'h00, 3'h0);
    $display("test reset done");
  endtask : test_reset
  task automatic test_priority();
    evt = 6'h01;
    wr(1'b0, 1'b1, 6'h01, 1'b1, 3'h0);
    repeat (4) @(negedge clk);
    chk(lines, 7'h00);
    for (int p = 1; p < 8; p++) begin
      wr(1'b0, 1'b0, 6'h00, 1'b1, 3'(p));
      @(negedge clk);
      chk(lines, 7'h01 << (p - 1));
      chk(7'(lvl), 7'(p));
    end
    rd(1'b0, 6'h01, 3'h7);
    $display("test priority done");
  endtask : test_priority
  task automatic test_events();
    wr(1'b0, 1'b0, 6'h00, 1'b1, 3'h5);
    for (int b = 0; b < 6; b++) begin
      wr(1'b0, 1'b1, 6'h01 << b, 1'b0, 3'h0);
      evt = ~(6'h01 << b);
      repeat (4) @(negedge clk);
      chk(lines, 7'h00);
      evt = 6'h01 << b;
      repeat (4) @(negedge clk);
      chk(lines, 7'h10);
      evt = 6'h00;
      repeat (4) @(negedge clk);
      chk(lines, 7'h00);
    end
    $display("test events done");
  endtask : test_events
  task automatic test_independence();
    wr(1'b0, 1'b1, 6'h01, 1'b0, 3'h0);
    wr(1'b1, 1'b1, 6'h20, 1'b1, 3'h2);
    evt = 6'h21;
    repeat (4) @(negedge clk);
    chk(lines, 7'h12);
    chk(7'(act), 7'h03);
    evt = 6'h20;
    repeat (4) @(negedge clk);
    chk(lines, 7'h02);
    chk(7'(act), 7'h02);
    wr(1'b1, 1'b1, 6'h08, 1'b0, 3'h0);
    rd(1'b0, 6'h01, 3'h5);
    rd(1'b1, 6'h08, 3'h2);
    $display("test independence done");
  endtask : test_independence
  initial begin
    repeat (5) @(negedge clk);
    nrst_n = 1'b1;
    test_reset();
    test_priority();
    test_events();
    test_independence();
    test_done();
  end
endmodule : testbench
